/* File: logic/bhc_pkg.sv */
// Shared constants and types for the bridge command sequencer
package bhc_pkg;

  // Bus address of the bridge (7 bits)
  localparam logic [6:0] BHC_DEV_ADDR       = 7'h18;

  // Command codes
  localparam logic [7:0] CMD_POINTER_SELECT = 8'he1;
  localparam logic [7:0] CMD_PORT_ADJUST    = 8'hc3;
  localparam logic [7:0] CMD_LINE_RESET     = 8'hb4;
  localparam logic [7:0] CMD_SINGLE_SLOT    = 8'h87;
  localparam logic [7:0] CMD_BYTE_WRITE     = 8'ha5;
  localparam logic [7:0] CMD_BYTE_READ      = 8'h96;

  // Read pointer codes
  localparam logic [7:0] PTR_STATUS         = 8'hf0;
  localparam logic [7:0] PTR_READ_DATA      = 8'he1;
  localparam logic [7:0] PTR_PORT_CFG       = 8'hb4;

  // Status byte layout
  localparam int         ST_BUSY_BIT        = 0;
  localparam int         ST_PRESENCE_BIT    = 1;
  localparam int         ST_SLOT_BIT        = 5;

  // Values after reset
  localparam logic [7:0] PORT_CFG_RESET     = 8'h00;
  localparam logic [7:0] PTR_RESET          = PTR_STATUS;

  // Line timing in ns at the system clock
  localparam int CLK_PERIOD_NS         = 4;
  localparam int LINE_RESET_LOW_NS     = 480000;
  localparam int LINE_PRESENCE_SMP_NS  = 70000;
  localparam int LINE_SLOT_NS          = 70000;
  localparam int LINE_ZERO_LOW_NS      = 60000;
  localparam int LINE_ONE_LOW_NS       = 6000;
  localparam int LINE_SAMPLE_NS        = 15000;

  // Cycle counts: least times round up, the sample point rounds down
  localparam int RESET_LOW_CYC    = (LINE_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESENCE_SMP_CYC = LINE_PRESENCE_SMP_NS / CLK_PERIOD_NS;
  localparam int SLOT_CYC         = (LINE_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ZERO_LOW_CYC     = (LINE_ZERO_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ONE_LOW_CYC      = (LINE_ONE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC       = LINE_SAMPLE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LINE_OP_RESET,
    LINE_OP_BIT,
    LINE_OP_WRITE,
    LINE_OP_READ
  } bhc_line_op_type;

endpackage

/* File: logic/bhc_line_engine.sv */
// Single-wire line engine: reset pulse, single slot, byte write and byte read
`timescale 1ns/1ps
`default_nettype none
module bhc_line_engine
  import bhc_pkg::*;
#(
  parameter int RST_LOW  = RESET_LOW_CYC,
  parameter int PRES_SMP = PRESENCE_SMP_CYC,
  parameter int SLOT     = SLOT_CYC,
  parameter int ZERO_LOW = ZERO_LOW_CYC
) (
  input  wire logic            clock_in,      // System clock
  input  wire logic            reset_n_in,    // Async reset, active low
  input  wire logic            start_in,      // Start pulse for one operation
  input  wire bhc_line_op_type op_in,         // Operation to run
  input  wire logic [7:0]      data_in,       // Byte to send, bit 7 for single slot
  input  wire logic            line_in,       // Line level
  output logic                 busy_out,      // Operation running
  output logic                 presence_out,  // Presence seen in last reset
  output logic                 slot_bit_out,  // Level sampled in last single slot
  output logic [7:0]           read_byte_out, // Last byte read
  output logic                 line_oe_out    // Pull the line low
);

  typedef enum logic [1:0] {E_IDLE, E_RESET, E_SLOT} bhc_eng_state_type;

  bhc_eng_state_type state, next_state;
  bhc_line_op_type   op, next_op;
  logic [19:0]       cnt, next_cnt;
  logic [2:0]        slots_left, next_slots_left;
  logic [7:0]        tx, next_tx;
  logic [7:0]        rx, next_rx;
  logic              next_busy, next_presence, next_slot_bit, next_oe;
  logic [7:0]        next_read_byte;

  always_comb begin
    next_state      = state;
    next_op         = op;
    next_cnt        = cnt + 20'd1;
    next_slots_left = slots_left;
    next_tx         = tx;
    next_rx         = rx;
    next_busy       = busy_out;
    next_presence   = presence_out;
    next_slot_bit   = slot_bit_out;
    next_read_byte  = read_byte_out;
    next_oe         = line_oe_out;
    case (state)
      E_IDLE: begin
        next_cnt = 20'd0;
        if (start_in) begin
          // Busy rises on the cycle after the accept
          next_busy       = 1'b1;
          next_op         = op_in;
          next_oe         = 1'b1;
          next_tx         = (op_in == LINE_OP_READ) ? 8'hff :
                            (op_in == LINE_OP_BIT) ? {7'h00, data_in[7]} : data_in;
          next_slots_left = (op_in == LINE_OP_BIT) ? 3'd0 : 3'd7;
          next_state      = (op_in == LINE_OP_RESET) ? E_RESET : E_SLOT;
        end
      end
      E_RESET: begin
        if (cnt == 20'(RST_LOW - 1)) begin
          next_oe = 1'b0;
        end
        if (cnt == 20'(RST_LOW + PRES_SMP - 1)) begin
          next_presence = ~line_in;
        end
        if (cnt == 20'(2 * RST_LOW - 1)) begin
          next_busy  = 1'b0;
          next_state = E_IDLE;
        end
      end
      E_SLOT: begin
        if (cnt == 20'((tx[0] ? ONE_LOW_CYC : ZERO_LOW) - 1)) begin
          next_oe = 1'b0;
        end
        if (cnt == 20'(SAMPLE_CYC - 1)) begin
          next_rx = {line_in, rx[7:1]};
          if (op == LINE_OP_BIT) begin
            next_slot_bit = line_in;
          end
        end
        if (cnt == 20'(SLOT - 1)) begin
          if (slots_left == 3'd0) begin
            // The read byte settles on the same edge that clears busy
            // read byte and idle on one edge
            if (op == LINE_OP_READ) begin
              next_read_byte = rx;
            end
            next_busy  = 1'b0;
            next_state = E_IDLE;
          end else begin
            next_slots_left = slots_left - 3'd1;
            next_tx         = {1'b0, tx[7:1]};
            next_cnt        = 20'd0;
            next_oe         = 1'b1;
          end
        end
      end
      default: next_state = E_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state         <= E_IDLE;
      op            <= LINE_OP_RESET;
      cnt           <= 20'd0;
      slots_left    <= 3'd0;
      tx            <= 8'h00;
      rx            <= 8'h00;
      busy_out      <= 1'b0;
      presence_out  <= 1'b0;
      slot_bit_out  <= 1'b0;
      read_byte_out <= 8'h00;
      line_oe_out   <= 1'b0;
    end else begin
      state         <= next_state;
      op            <= next_op;
      cnt           <= next_cnt;
      slots_left    <= next_slots_left;
      tx            <= next_tx;
      rx            <= next_rx;
      busy_out      <= next_busy;
      presence_out  <= next_presence;
      slot_bit_out  <= next_slot_bit;
      read_byte_out <= next_read_byte;
      line_oe_out   <= next_oe;
    end
  end

endmodule
`default_nettype wire

/* File: logic/bhc_bridge.sv */
// Serial bus slave that sequences commands for the single-wire line engine
`timescale 1ns/1ps
`default_nettype none
module bhc_bridge
  import bhc_pkg::*;
#(
  parameter int RST_LOW  = RESET_LOW_CYC,
  parameter int PRES_SMP = PRESENCE_SMP_CYC,
  parameter int SLOT     = SLOT_CYC,
  parameter int ZERO_LOW = ZERO_LOW_CYC
) (
  input  wire logic clock_in,     // System clock, 250 MHz
  input  wire logic reset_n_in,   // Async reset, active low
  input  wire logic scl_in,       // Serial clock level
  input  wire logic sda_in,       // Serial data level
  output logic      sda_out_out,  // Serial data drive value, always low
  output logic      sda_oe_out,   // Serial data pulled low while high
  input  wire logic line_in,      // Single-wire line level
  output logic      line_out_out, // Line drive value, always low
  output logic      line_oe_out   // Line pulled low while high
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_WR, S_ACK, S_TX, S_MACK, S_IGNORE} bhc_state_type;

  bhc_state_type   state, next_state;
  logic            scl_q, sda_q;
  logic [3:0]      bit_cnt, next_bit_cnt;
  logic [7:0]      rx, next_rx;
  logic [7:0]      tx, next_tx;
  logic            rw, next_rw;
  logic [1:0]      byte_idx, next_byte_idx;
  logic [7:0]      cmd, next_cmd;
  logic            refuse, next_refuse;
  logic            mack, next_mack;
  logic            sda_oe, next_sda_oe;
  logic [7:0]      rd_ptr, next_rd_ptr;
  logic [7:0]      port_cfg [8];
  logic [7:0]      next_port_cfg [8];
  logic [2:0]      port_idx, next_port_idx;
  logic            line_start, next_line_start;
  bhc_line_op_type line_op, next_line_op;
  logic [7:0]      line_data, next_line_data;
  logic            pin_low;
  logic            scl_rise, scl_fall, bus_start, bus_stop;
  logic            wr_eval, ack, code_ok, accept, load_tx;
  logic [7:0]      acc_code, tx_byte;
  logic            line_busy, presence, slot_bit;
  logic [7:0]      read_byte;

  assign scl_rise  = ~scl_q & scl_in;
  assign scl_fall  = scl_q & ~scl_in;
  assign bus_start = scl_q & scl_in & sda_q & ~sda_in;
  assign bus_stop  = scl_q & scl_in & ~sda_q & sda_in;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_rx         = rx;
    next_tx         = tx;
    next_rw         = rw;
    next_byte_idx   = byte_idx;
    next_cmd        = cmd;
    next_refuse     = refuse;
    next_mack       = mack;
    next_sda_oe     = sda_oe;
    next_rd_ptr     = rd_ptr;
    next_port_cfg   = port_cfg;
    next_port_idx   = port_idx;
    next_line_start = 1'b0;
    next_line_op    = line_op;
    next_line_data  = line_data;
    wr_eval         = 1'b0;
    ack             = 1'b0;
    code_ok         = 1'b0;
    accept          = 1'b0;
    acc_code        = 8'h00;
    load_tx         = 1'b0;
    tx_byte         = 8'h00;
    case (state)
      S_ADDR, S_WR: begin
        if (scl_rise) begin
          next_rx      = {rx[6:0], sda_in};
          next_bit_cnt = bit_cnt + 4'd1;
        end
        if (scl_fall && bit_cnt == 4'd8) begin
          if (state == S_ADDR) begin
            if (rx[7:1] == BHC_DEV_ADDR) begin
              next_sda_oe   = 1'b1;
              next_rw       = rx[0];
              next_byte_idx = 2'd0;
              next_refuse   = 1'b0;
              next_state    = S_ACK;
            end else begin
              next_state = S_IGNORE;
            end
          end else begin
            wr_eval = 1'b1;
          end
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          next_bit_cnt = 4'd0;
          next_sda_oe  = 1'b0;
          next_state   = S_WR;
          if (rw) begin
            load_tx    = 1'b1;
            next_state = S_TX;
          end
        end
      end
      S_TX: begin
        if (scl_rise) begin
          next_bit_cnt = bit_cnt + 4'd1;
        end
        if (scl_fall) begin
          if (bit_cnt == 4'd8) begin
            next_sda_oe = 1'b0;
            next_state  = S_MACK;
          end else begin
            // Open-drain: a one releases the line
            next_tx     = {tx[6:0], 1'b0};
            next_sda_oe = ~tx[6];
          end
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          next_mack = ~sda_in;
        end
        if (scl_fall) begin
          next_bit_cnt = 4'd0;
          next_state   = S_IGNORE;
          if (mack) begin
            load_tx    = 1'b1;
            next_state = S_TX;
          end
        end
      end
      default: next_state = state;
    endcase

    if (wr_eval) begin
      if (!refuse && byte_idx == 2'd0) begin
        code_ok = rx == CMD_POINTER_SELECT || rx == CMD_PORT_ADJUST || rx == CMD_LINE_RESET ||
                  rx == CMD_SINGLE_SLOT || rx == CMD_BYTE_WRITE || rx == CMD_BYTE_READ;
        ack = code_ok && (!line_busy || rx == CMD_POINTER_SELECT);
        if (ack) begin
          next_cmd = rx;
          if (rx == CMD_LINE_RESET || rx == CMD_BYTE_READ) begin
            accept   = 1'b1;
            acc_code = rx;
          end
        end
      end else if (!refuse && byte_idx == 2'd1) begin
        ack = (cmd == CMD_POINTER_SELECT) ?
              (rx == PTR_STATUS || rx == PTR_READ_DATA || rx == PTR_PORT_CFG) :
              (cmd == CMD_PORT_ADJUST || cmd == CMD_SINGLE_SLOT || cmd == CMD_BYTE_WRITE);
        accept   = ack;
        acc_code = cmd;
      end
      next_sda_oe   = ack;
      next_refuse   = refuse | ~ack;
      next_state    = S_ACK;
      next_byte_idx = (byte_idx == 2'd2) ? byte_idx : byte_idx + 2'd1;
    end

    if (accept) begin
      next_port_idx = 3'd0;
      case (acc_code)
        CMD_POINTER_SELECT: next_rd_ptr = rx;
        CMD_PORT_ADJUST: begin
          next_port_cfg[rx[7:5]] = rx;
          next_rd_ptr            = PTR_PORT_CFG;
        end
        default: begin
          next_line_start = 1'b1;
          next_line_data  = rx;
          next_rd_ptr     = PTR_STATUS;
          next_line_op    = (acc_code == CMD_LINE_RESET) ? LINE_OP_RESET :
                            (acc_code == CMD_SINGLE_SLOT) ? LINE_OP_BIT :
                            (acc_code == CMD_BYTE_WRITE) ? LINE_OP_WRITE : LINE_OP_READ;
        end
      endcase
    end

    if (load_tx) begin
      case (rd_ptr)
        PTR_STATUS: begin
          tx_byte[ST_BUSY_BIT]     = line_busy;
          tx_byte[ST_PRESENCE_BIT] = presence;
          tx_byte[ST_SLOT_BIT]     = slot_bit;
        end
        PTR_READ_DATA: tx_byte = read_byte;
        default: begin
          tx_byte       = port_cfg[port_idx];
          next_port_idx = port_idx + 3'd1;
        end
      endcase
      next_tx     = tx_byte;
      next_sda_oe = ~tx_byte[7];
    end

    if (bus_start) begin
      next_state   = S_ADDR;
      next_bit_cnt = 4'd0;
      next_sda_oe  = 1'b0;
    end else if (bus_stop) begin
      next_state  = S_IDLE;
      next_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state      <= S_IDLE;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      bit_cnt    <= 4'd0;
      rx         <= 8'h00;
      tx         <= 8'h00;
      rw         <= 1'b0;
      byte_idx   <= 2'd0;
      cmd        <= 8'h00;
      refuse     <= 1'b0;
      mack       <= 1'b0;
      sda_oe     <= 1'b0;
      rd_ptr     <= PTR_RESET;
      port_cfg   <= '{default: PORT_CFG_RESET};
      port_idx   <= 3'd0;
      line_start <= 1'b0;
      line_op    <= LINE_OP_RESET;
      line_data  <= 8'h00;
      pin_low    <= 1'b0;
    end else begin
      state      <= next_state;
      scl_q      <= scl_in;
      sda_q      <= sda_in;
      bit_cnt    <= next_bit_cnt;
      rx         <= next_rx;
      tx         <= next_tx;
      rw         <= next_rw;
      byte_idx   <= next_byte_idx;
      cmd        <= next_cmd;
      refuse     <= next_refuse;
      mack       <= next_mack;
      sda_oe     <= next_sda_oe;
      rd_ptr     <= next_rd_ptr;
      port_cfg   <= next_port_cfg;
      port_idx   <= next_port_idx;
      line_start <= next_line_start;
      line_op    <= next_line_op;
      line_data  <= next_line_data;
      pin_low    <= 1'b0;
    end
  end

  assign sda_out_out  = pin_low;
  assign sda_oe_out   = sda_oe;
  assign line_out_out = pin_low;

  bhc_line_engine #(
    .RST_LOW  (RST_LOW),
    .PRES_SMP (PRES_SMP),
    .SLOT     (SLOT),
    .ZERO_LOW (ZERO_LOW)
  ) u_engine (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .start_in      (line_start),
    .op_in         (line_op),
    .data_in       (line_data),
    .line_in       (line_in),
    .busy_out      (line_busy),
    .presence_out  (presence),
    .slot_bit_out  (slot_bit),
    .read_byte_out (read_byte),
    .line_oe_out   (line_oe_out)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  AST_SDA_OPEN_DRAIN: assert property (sda_out_out == 1'b0 && line_out_out == 1'b0)
    else $error("data pin drives a high level");
  AST_ADJ_POINTS_PORT: assert property (accept && acc_code == CMD_PORT_ADJUST |=>
    rd_ptr == PTR_PORT_CFG && port_idx == 3'd0) else $error("port adjust did not select port config");
  AST_BUSY_REFUSES: assert property (wr_eval && byte_idx == 2'd0 && line_busy &&
    rx != CMD_POINTER_SELECT |=> !sda_oe_out) else $error("command acknowledged while busy");
  AST_SURPLUS_NACK: assert property (wr_eval && byte_idx == 2'd2 |=> !sda_oe_out ##1 !accept)
    else $error("surplus byte acknowledged");
  AST_STATUS_BUSY: assert property (load_tx && rd_ptr == PTR_STATUS |=>
    tx[ST_BUSY_BIT] == $past(line_busy)) else $error("status byte lost busy flag");
  AST_START_BUSY: assert property (line_start |=> line_busy [*8])
    else $error("busy not held after line start");
  AST_RESULT_STABLE: assert property (!line_busy && !$past(line_busy) |->
    $stable(slot_bit) && $stable(read_byte)) else $error("result changed while idle");
  AST_SELECT_WHILE_BUSY: assert property (wr_eval && byte_idx == 2'd1 && !refuse &&
    cmd == CMD_POINTER_SELECT && rx == PTR_READ_DATA |=> sda_oe_out && rd_ptr == PTR_READ_DATA)
    else $error("read data select refused");
  AST_PTR_HOLDS: assert property ($changed(rd_ptr) |-> $past(accept))
    else $error("read pointer moved without a command");
  AST_PORT_STEP: assert property (load_tx && rd_ptr == PTR_PORT_CFG |=>
    port_idx == $past(port_idx) + 3'd1) else $error("port entry did not advance");
  AST_READ_DECODE: assert property (accept && acc_code == CMD_BYTE_READ |=>
    line_start && line_op == LINE_OP_READ) else $error("byte read code not decoded");

  COV_BUSY_REFUSAL: cover property (wr_eval && byte_idx == 2'd0 && line_busy && !ack);
  COV_READ_DATA_WHILE_BUSY: cover property (accept && acc_code == CMD_POINTER_SELECT && line_busy);
  COV_STATUS_POLL: cover property (load_tx && rd_ptr == PTR_STATUS && line_busy);
  COV_PORT_READ: cover property (load_tx && rd_ptr == PTR_PORT_CFG && port_idx == 3'd1);

endmodule
`default_nettype wire

/* File: sim/bhc_host_model.sv */
// Serial bus master model that drives the bridge from the host side
`timescale 1ns/1ps
`default_nettype none
module bhc_host_model (
  input  wire logic clock_in,     // System clock
  input  wire logic sda_in,       // Resolved data wire
  output logic      scl_out,      // Serial clock, push-pull
  output logic      sda_pull_out  // Pull data wire low while high
);
  initial begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end
  // Signals change one fixed step after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Works as first or repeated start
  task automatic start();
    sda_pull_out = 1'b0;
    tick(8);
    scl_out = 1'b1;
    tick(8);
    sda_pull_out = 1'b1;
    tick(8);
    scl_out = 1'b0;
    tick(8);
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    tick(8);
    scl_out = 1'b1;
    tick(8);
    sda_pull_out = 1'b0;
    tick(8);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_pull_out = ~b;
    tick(8);
    scl_out = 1'b1;
    tick(4);
    s = sda_in;
    tick(4);
    scl_out = 1'b0;
  endtask
  // Byte plus ack slot; a read byte is nacked when last, or when polling and busy reads 0
  task automatic xfer(input logic [7:0] d, input logic poll, input logic last,
                      output logic [7:0] q, output logic s);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(last | (poll & ~q[0]), s);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the bridge command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bhc_pkg::*;
  logic        clock_in;
  logic        reset_n_in;
  logic        scl_in;
  logic        sda_in;
  logic        sda_out_out;
  logic        sda_oe_out;
  logic        line_in;
  logic        line_out_out;
  logic        line_oe_out;
  logic        host_pull;
  logic [31:0] seed;
  logic [7:0]  f;
  logic [7:0]  l;
  logic [7:0]  p;
  logic        b;
  int          err_total;
  int          cmp_count;
  int          low_cnt;
  int          pres_cnt;

  initial clock_in = 1'b0;
  always #2 clock_in = ~clock_in;

  assign sda_in  = ~(sda_oe_out | host_pull);
  assign line_in = ~(line_oe_out | (pres_cnt > 0));

  // Line slave: answers a reset pulse with presence, otherwise leaves the line to the pull-up
  initial low_cnt = 0;
  initial pres_cnt = 0;
  always @(posedge clock_in) begin
    low_cnt <= line_oe_out ? low_cnt + 1 : 0;
    if (!line_oe_out && low_cnt > 30 && low_cnt < 100) pres_cnt <= 20;
    else if (pres_cnt > 0) pres_cnt <= pres_cnt - 1;
  end

  bhc_host_model i_bhc_host_model (
    .clock_in     (clock_in),
    .sda_in       (sda_in),
    .scl_out      (scl_in),
    .sda_pull_out (host_pull)
  );

  bhc_bridge #(.RST_LOW(40), .PRES_SMP(10), .SLOT(4000), .ZERO_LOW(3800)) i_bhc_bridge (
    .clock_in     (clock_in),
    .reset_n_in   (reset_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out_out  (sda_out_out),
    .sda_oe_out   (sda_oe_out),
    .line_in      (line_in),
    .line_out_out (line_out_out),
    .line_oe_out  (line_oe_out)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Write access of n bytes; e holds the expected acks of address and bytes
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n, input logic [3:0] e);
    logic [7:0] q;
    logic [3:0] a;
    logic       s;
    a = 4'h0;
    i_bhc_host_model.start();
    i_bhc_host_model.xfer({BHC_DEV_ADDR, 1'b0}, 1'b0, 1'b1, q, s);
    a[3] = ~s;
    i_bhc_host_model.xfer(c, 1'b0, 1'b1, q, s);
    a[2] = ~s;
    if (n > 1) begin
      i_bhc_host_model.xfer(d, 1'b0, 1'b1, q, s);
      a[1] = ~s;
    end
    if (n > 2) begin
      i_bhc_host_model.xfer(8'h00, 1'b0, 1'b1, q, s);
      a[0] = ~s;
    end
    i_bhc_host_model.stop();
    chk({4'h0, a}, {4'h0, e});
  endtask

  // Read access of up to n bytes, ending early once busy reads 0 when polling
  task automatic rd(input int n, input logic poll, output logic [7:0] fq, output logic [7:0] lq);
    logic [7:0] q;
    logic       s;
    int         i;
    i = 0;
    q = 8'h01;
    i_bhc_host_model.start();
    i_bhc_host_model.xfer({BHC_DEV_ADDR, 1'b1}, 1'b0, 1'b1, q, s);
    q = 8'h01;
    while (i < n && !(poll && i > 0 && q[0] === 1'b0)) begin
      i_bhc_host_model.xfer(8'hff, poll, i == n - 1, q, s);
      if (i == 0) fq = q;
      lq = q;
      i++;
    end
    i_bhc_host_model.stop();
  endtask

  // Pins only ever pull low
  always @(negedge clock_in) begin
    if (reset_n_in) chk({6'h00, sda_out_out, line_out_out}, 8'h00);
  end

  initial begin
    repeat (95000) @(posedge clock_in);
    err_total++;
    give_verdict();
  end

  initial begin
    err_total  = 0;
    cmp_count  = 0;
    seed       = 32'ha775;
    reset_n_in = 1'b0;
    repeat (3) @(posedge clock_in);
    #1 reset_n_in = 1'b1;
    repeat (4) @(posedge clock_in);
    seed = lfsr_next(seed);
    p = {3'd1, seed[4:0]};
    wr(CMD_PORT_ADJUST, p, 2, 4'b1110);
    rd(2, 1'b0, f, l);
    chk(f, 8'h00);
    chk(l, p);
    wr(8'h12, 8'h00, 1, 4'b1000);
    wr(CMD_POINTER_SELECT, PTR_STATUS, 3, 4'b1110);
    wr(CMD_POINTER_SELECT, 8'h55, 2, 4'b1100);
    wr(CMD_LINE_RESET, 8'h00, 1, 4'b1100);
    repeat (200) @(posedge clock_in);
    rd(1, 1'b0, f, l);
    chk(f, 8'h02);
    seed = lfsr_next(seed);
    b = seed[0];
    wr(CMD_SINGLE_SLOT, {b, 7'h00}, 2, 4'b1110);
    wr(CMD_BYTE_WRITE, 8'h00, 2, 4'b1000);
    rd(200, 1'b1, f, l);
    chk({7'h00, f[0]}, 8'h01);
    chk(l, {2'b00, b, 3'b000, 2'b10});
    wr(CMD_BYTE_READ, 8'h00, 1, 4'b1100);
    wr(CMD_POINTER_SELECT, PTR_READ_DATA, 2, 4'b1110);
    repeat (8 * 4000 + 200) @(posedge clock_in);
    rd(1, 1'b0, f, l);
    chk(f, 8'hff);
    seed = lfsr_next(seed);
    wr(CMD_BYTE_WRITE, seed[7:0], 2, 4'b1110);
    rd(250, 1'b1, f, l);
    chk({6'h00, f[0], l[0]}, 8'h02);
    wr(CMD_POINTER_SELECT, PTR_READ_DATA, 2, 4'b1110);
    rd(1, 1'b0, f, l);
    chk(f, 8'hff);
    wr(CMD_POINTER_SELECT, PTR_PORT_CFG, 2, 4'b1110);
    rd(2, 1'b0, f, l);
    chk(f, 8'h00);
    chk(l, p);
    give_verdict();
  end
endmodule
`default_nettype wire
